// ### src/wm_pkg.sv
// Constants, types and carriers of the word move / byte arithmetic unit.
// Assumes one 100 MHz clock and a decoder that hands over decoded commands.
package wm_pkg;
  // ----------------------------------------------------------------
  // Addresses and constant values
  // ----------------------------------------------------------------
  localparam logic [3:0] WM_DEF_BANK = 4'hf;
  localparam logic [15:0] WM_SADDR_BASE = 16'hfe20;
  localparam logic [15:0] WM_WORD_ONE = 16'h0001;
  localparam logic [15:0] WM_WORD_ZERO = 16'h0000;
  localparam logic [7:0] WM_BYTE_ZERO = 8'h00;
  // ----------------------------------------------------------------
  // Clock and byte counts
  // ----------------------------------------------------------------
  localparam logic [3:0] WM_CLK_BASE = 4'h1;
  localparam logic [3:0] WM_CLK_PFX = 4'h2;
  localparam logic [3:0] WM_CLK_FL = 4'h4;
  localparam logic [3:0] WM_CLK_FL_PFX = 4'h5;
  localparam logic [3:0] WM_CLK_RMW = 4'h2;
  localparam logic [3:0] WM_CLK_RAMF = 4'h3;
  localparam logic [2:0] WM_LEN_1 = 3'h1;
  localparam logic [2:0] WM_LEN_2 = 3'h2;
  localparam logic [2:0] WM_LEN_3 = 3'h3;
  // ----------------------------------------------------------------
  // Register indices: byte r and pair rp; nibble and byte carry masks
  // ----------------------------------------------------------------
  localparam logic [2:0] WM_R_X = 3'h0;
  localparam logic [2:0] WM_R_A = 3'h1;
  localparam logic [1:0] WM_RP_AX = 2'h0;
  localparam logic [1:0] WM_RP_BC = 2'h1;
  localparam logic [4:0] WM_NIB = 5'h10;
  localparam logic [8:0] WM_BYTE_C = 9'h100;

  typedef enum logic [3:0] {OP_LDW, OP_STW, OP_LDRP, OP_WORD_SWAP, OP_WORD_SET_ONE,
    OP_WORD_ZERO, OP_ADD, OP_SUM_WITH_CARRY, OP_SUB, OP_DIFF_WITH_BORROW, OP_AND} wm_op_t;
  typedef enum logic [3:0] {AM_DE, AM_HL, AM_DE_D, AM_HL_D, AM_SP_D,
    AM_B_W, AM_C_W, AM_BC_W, AM_ABS, AM_SADDR, AM_HL_B, AM_HL_C} wm_am_t;
  typedef enum logic [1:0] {SRC_IMM, SRC_REG, SRC_MEM} wm_src_t;
  typedef enum logic [1:0] {DST_A, DST_REG, DST_SADDR} wm_dst_t;
  typedef enum logic [1:0] {RG_RAM, RG_CODE, RG_DATA} wm_region_t;

  typedef struct packed {
    wm_op_t op;
    wm_am_t am;
    wm_src_t src;
    wm_dst_t dst;
    logic pfx;
    logic [2:0] r;
    logic [1:0] rp;
    logic [7:0] disp;
    logic [15:0] word;
    logic [7:0] imm;
  } wm_cmd_t;

  typedef struct packed {
    logic [19:0] addr;
    logic rd;
    logic wr;
    logic wide;
    logic [15:0] wdata;
  } wm_mreq_t;

  typedef struct packed {
    logic z;
    logic ac;
    logic cy;
  } wm_flags_t;

  typedef struct packed {
    logic [15:0] ax;
    logic [15:0] bc;
    logic [15:0] de;
    logic [15:0] hl;
    logic [15:0] sp;
    logic [3:0] es;
    wm_flags_t f;
  } wm_arch_t;
endpackage

// ### src/wm_alu.sv
// Byte arithmetic and conjunction with flag results.
// Pure combinational; the caller latches result and flags.
`timescale 1ns/1ns
module wm_alu
  import wm_pkg::*;
(
  // Operation and operands
  input wire wm_pkg::wm_op_t op,
  input wire logic [7:0] a,
  input wire logic [7:0] b,
  input wire wm_pkg::wm_flags_t fin,
  // Result
  output logic [7:0] res,
  output wm_pkg::wm_flags_t fout
);
  import wm_pkg::*;
  logic ci;
  logic [8:0] full;
  logic [4:0] nib;

  always_comb
  begin
    ci = ((op == OP_SUM_WITH_CARRY) || (op == OP_DIFF_WITH_BORROW)) ? fin.cy : 1'b0;
    full = '0;
    nib = '0;
    fout = fin;
    res = a & b;
    if ((op == OP_ADD) || (op == OP_SUM_WITH_CARRY))
    begin
      full = {1'b0, a} + {1'b0, b} + {8'h00, ci};
      nib = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
    end
    else if ((op == OP_SUB) || (op == OP_DIFF_WITH_BORROW))
    begin
      full = {1'b0, a} - {1'b0, b} - {8'h00, ci};
      nib = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, ci};
    end
    if (op != OP_AND)
    begin
      res = full[7:0];
      fout.cy = |(full & WM_BYTE_C);
      fout.ac = |(nib & WM_NIB);
    end
    fout.z = (res == WM_BYTE_ZERO);
  end
endmodule

// ### src/wm_agu.sv
// Operand address generation for every memory form.
// Offsets wrap inside 16 bits; the bank sits above them.
`timescale 1ns/1ns
module wm_agu
  import wm_pkg::*;
(
  // Command and architectural state
  input wire wm_pkg::wm_cmd_t cmd,
  input wire wm_pkg::wm_arch_t arch,
  // Resulting address
  output logic [19:0] addr
);
  import wm_pkg::*;
  logic [15:0] off;
  logic [7:0] sa;

  always_comb
  begin
    sa = (cmd.dst == DST_SADDR) ? cmd.imm : cmd.disp;
    case (cmd.am)
      AM_DE: off = arch.de;
      AM_HL: off = arch.hl;
      AM_DE_D: off = arch.de + {8'h00, cmd.disp};
      AM_HL_D: off = arch.hl + {8'h00, cmd.disp};
      AM_SP_D: off = arch.sp + {8'h00, cmd.disp};
      AM_B_W: off = cmd.word + {8'h00, arch.bc[15:8]};
      AM_C_W: off = cmd.word + {8'h00, arch.bc[7:0]};
      AM_BC_W: off = cmd.word + arch.bc;
      AM_ABS: off = cmd.word;
      AM_SADDR: off = WM_SADDR_BASE + {8'h00, sa};
      AM_HL_B: off = arch.hl + {8'h00, arch.bc[15:8]};
      default: off = arch.hl + {8'h00, arch.bc[7:0]};
    endcase
    // Stack and short forms stay in the default bank
    if (cmd.pfx && (cmd.am != AM_SP_D) && (cmd.am != AM_SADDR))
      addr = {arch.es, off};
    else
      addr = {WM_DEF_BANK, off};
  end
endmodule

// ### src/wm_exec.sv
// Execution unit: word transfers and byte arithmetic with timing.
// Assumes memory answers combinationally in the cycle of the read strobe.
`timescale 1ns/1ns
module wm_exec
  import wm_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Command handshake
  input wire logic cmd_valid,
  input wire wm_pkg::wm_cmd_t cmd,
  input wire logic fetch_ram,
  output logic cmd_ready,
  output logic done,
  output logic [2:0] instr_len,
  // Bank and stack loads, taken while idle
  input wire logic es_wr,
  input wire logic [3:0] es_wdata,
  input wire logic sp_wr,
  input wire logic [15:0] sp_wdata,
  // Memory port
  output wm_pkg::wm_mreq_t mreq,
  input wire logic [15:0] mem_rdata,
  input wire wm_pkg::wm_region_t mem_region,
  // Architectural state
  output wm_pkg::wm_arch_t arch
);
  import wm_pkg::*;

  typedef enum logic {ST_IDLE, ST_EXEC} wm_st_t;
  typedef struct packed {
    wm_st_t st;
    wm_cmd_t cmd;
    logic fram;
    logic [7:0][7:0] rf;
    logic [15:0] sp;
    logic [3:0] es;
    wm_flags_t f;
    logic [3:0] cnt;
    logic [15:0] tmp;
    logic [2:0] len;
  } wm_state_t;

  wm_state_t s_r;
  wm_state_t s_nxt;
  wm_arch_t arch_v;
  logic [19:0] addr;
  logic [3:0] target;
  logic is_rd;
  logic is_wr;
  logic is_byte;
  logic last;
  logic [15:0] opnd;
  logic [7:0] alu_a;
  logic [7:0] alu_b;
  logic [7:0] alu_res;
  wm_flags_t alu_f;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [2:0] len_of(input wm_cmd_t c);
    logic [2:0] n;
    n = WM_LEN_2;
    if ((c.op == OP_WORD_SWAP) || (c.op == OP_WORD_SET_ONE) || (c.op == OP_WORD_ZERO))
      n = WM_LEN_1;
    else if (c.dst == DST_SADDR)
      n = WM_LEN_3;
    else if ((c.op >= OP_ADD) && (c.src != SRC_MEM))
      n = WM_LEN_2;
    else if ((c.am == AM_DE) || (c.am == AM_HL))
      n = WM_LEN_1;
    else if ((c.am >= AM_B_W) && (c.am <= AM_ABS))
      n = WM_LEN_3;
    if (c.pfx && (c.am != AM_SP_D) && (c.am != AM_SADDR))
      n = n + WM_LEN_1;
    return n;
  endfunction

  assign arch_v.ax = {s_r.rf[WM_R_A], s_r.rf[WM_R_X]};
  assign arch_v.bc = {s_r.rf[3], s_r.rf[2]};
  assign arch_v.de = {s_r.rf[5], s_r.rf[4]};
  assign arch_v.hl = {s_r.rf[7], s_r.rf[6]};
  assign arch_v.sp = s_r.sp;
  assign arch_v.es = s_r.es;
  assign arch_v.f = s_r.f;
  assign arch = arch_v;

  wm_agu u_agu (
    .cmd(s_r.cmd),
    .arch(arch_v),
    .addr(addr)
  );

  // ----------------------------------------------------------------
  // Clock count
  // ----------------------------------------------------------------
  always_comb
  begin
    is_byte = (s_r.cmd.op >= OP_ADD);
    is_rd = (s_r.cmd.op == OP_LDW) || (s_r.cmd.op == OP_LDRP) ||
            (is_byte && (s_r.cmd.src == SRC_MEM)) ||
            (s_r.cmd.dst == DST_SADDR);
    is_wr = (s_r.cmd.op == OP_STW) || (s_r.cmd.dst == DST_SADDR);
    // Region answers from the address alone, so it holds for the command
    if (is_byte && (s_r.cmd.dst == DST_SADDR))
      target = WM_CLK_RMW;
    else if (is_rd && (s_r.cmd.am != AM_SP_D) &&
             (s_r.cmd.am != AM_SADDR) &&
             ((mem_region == RG_CODE) ||
              ((mem_region == RG_DATA) && is_byte)))
      target = s_r.cmd.pfx ? WM_CLK_FL_PFX : WM_CLK_FL;
    else if ((is_rd || is_wr) && s_r.cmd.pfx &&
             (s_r.cmd.am != AM_SP_D) && (s_r.cmd.am != AM_SADDR))
      target = WM_CLK_PFX;
    else
      target = WM_CLK_BASE;
    // Worst case when the program runs from RAM
    if (s_r.fram)
      target = target + target + WM_CLK_RAMF;
    last = (s_r.st == ST_EXEC) && (s_r.cnt == target);
  end

  // ----------------------------------------------------------------
  // Operands and memory strobes
  // ----------------------------------------------------------------
  always_comb
  begin
    opnd = (s_r.cnt == WM_CLK_BASE) ? mem_rdata : s_r.tmp;
    alu_a = s_r.rf[WM_R_A];
    alu_b = s_r.cmd.imm;
    if (s_r.cmd.dst == DST_SADDR)
      alu_a = opnd[7:0];
    else if (s_r.cmd.dst == DST_REG)
    begin
      alu_a = s_r.rf[s_r.cmd.r];
      alu_b = s_r.rf[WM_R_A];
    end
    else if (s_r.cmd.src == SRC_REG)
      alu_b = s_r.rf[s_r.cmd.r];
    else if (s_r.cmd.src == SRC_MEM)
      alu_b = opnd[7:0];
    mreq.addr = addr;
    mreq.rd = (s_r.st == ST_EXEC) && is_rd && (s_r.cnt == WM_CLK_BASE);
    mreq.wr = last && is_wr;
    mreq.wide = !is_byte;
    mreq.wdata = is_byte ? {8'h00, alu_res} : arch_v.ax;
  end

  wm_alu u_alu (
    .op(s_r.cmd.op),
    .a(alu_a),
    .b(alu_b),
    .fin(s_r.f),
    .res(alu_res),
    .fout(alu_f)
  );

  assign cmd_ready = (s_r.st == ST_IDLE);
  assign done = last;
  assign instr_len = s_r.len;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    s_nxt = s_r;
    case (s_r.st)
      ST_IDLE:
      begin
        if (es_wr)
          s_nxt.es = es_wdata;
        if (sp_wr)
          s_nxt.sp = sp_wdata;
        if (cmd_valid)
        begin
          s_nxt.st = ST_EXEC;
          s_nxt.cmd = cmd;
          s_nxt.fram = fetch_ram;
          s_nxt.len = len_of(cmd);
          s_nxt.cnt = WM_CLK_BASE;
        end
      end
      default:
      begin
        s_nxt.cnt = s_r.cnt + WM_CLK_BASE;
        if (mreq.rd)
          s_nxt.tmp = mem_rdata;
        if (last)
        begin
          s_nxt.st = ST_IDLE;
          case (s_r.cmd.op)
            OP_LDW:
              {s_nxt.rf[WM_R_A], s_nxt.rf[WM_R_X]} = opnd;
            OP_LDRP:
              {s_nxt.rf[{s_r.cmd.rp, 1'b1}],
               s_nxt.rf[{s_r.cmd.rp, 1'b0}]} = opnd;
            OP_WORD_SWAP:
            begin
              {s_nxt.rf[WM_R_A], s_nxt.rf[WM_R_X]} =
                {s_r.rf[{s_r.cmd.rp, 1'b1}], s_r.rf[{s_r.cmd.rp, 1'b0}]};
              {s_nxt.rf[{s_r.cmd.rp, 1'b1}],
               s_nxt.rf[{s_r.cmd.rp, 1'b0}]} = arch_v.ax;
            end
            // Only AX and BC take the constants; rp[0] picks BC
            OP_WORD_SET_ONE:
              {s_nxt.rf[{1'b0, s_r.cmd.rp[0], 1'b1}],
               s_nxt.rf[{1'b0, s_r.cmd.rp[0], 1'b0}]} = WM_WORD_ONE;
            OP_WORD_ZERO:
              {s_nxt.rf[{1'b0, s_r.cmd.rp[0], 1'b1}],
               s_nxt.rf[{1'b0, s_r.cmd.rp[0], 1'b0}]} = WM_WORD_ZERO;
            OP_STW: s_nxt.tmp = s_r.tmp;
            default:
            begin
              s_nxt.f = alu_f;
              if (s_r.cmd.dst == DST_A)
                s_nxt.rf[WM_R_A] = alu_res;
              else if (s_r.cmd.dst == DST_REG)
                s_nxt.rf[s_r.cmd.r] = alu_res;
            end
          endcase
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  logic first;
  assign first = (s_r.st == ST_EXEC) && (s_r.cnt == WM_CLK_BASE);

  sequence s_wait4;
    !done [*4] ##1 done;
  endsequence
  sequence s_wait3;
    !done [*3] ##1 done;
  endsequence

  AST_IND_ONE: assert property (first && !s_r.fram && !s_r.cmd.pfx &&
    (s_r.cmd.op == OP_LDW) && (mem_region == RG_RAM) |-> done)
    else $error("indirect word load not one clock");
  AST_PFX_TWO: assert property (first && !s_r.fram && s_r.cmd.pfx &&
    (s_r.cmd.op == OP_STW) && (s_r.cmd.am != AM_SP_D) |-> !done ##1 done)
    else $error("prefixed store not two clocks");
  AST_FL_FOUR: assert property (first && !s_r.fram && !s_r.cmd.pfx &&
    (s_r.cmd.op <= OP_LDRP) && is_rd && (s_r.cmd.am != AM_SP_D) &&
    (s_r.cmd.am != AM_SADDR) && (mem_region == RG_CODE) |-> s_wait3)
    else $error("flash read not four clocks");
  // Prefixed stretch: word read from code, or byte read from either flash
  AST_FL_FIVE: assert property (first && !s_r.fram && s_r.cmd.pfx &&
    (s_r.cmd.am != AM_SP_D) && (s_r.cmd.am != AM_SADDR) &&
    (((s_r.cmd.op <= OP_LDRP) && is_rd && (mem_region == RG_CODE)) ||
     (is_byte && (s_r.cmd.src == SRC_MEM) && (s_r.cmd.dst == DST_A) &&
      (mem_region != RG_RAM))) |-> s_wait4)
    else $error("prefixed flash read not five clocks");
  AST_SP_ONE: assert property (first && !s_r.fram &&
    (s_r.cmd.am == AM_SP_D) && (s_r.cmd.op <= OP_STW) |-> done)
    else $error("stack relative move not one clock");
  // Any command without a data access shows the full RAM-fetch stretch
  AST_RAMF: assert property (first && s_r.fram && !is_rd && !is_wr |->
    s_wait4)
    else $error("ram fetch count not twice plus three");
  AST_ONE_VAL: assert property (done && (s_r.cmd.op == OP_WORD_SET_ONE) |=>
    ((($past(s_r.cmd.rp[0]) ? arch.bc : arch.ax)) == WM_WORD_ONE))
    else $error("set-one value wrong");
  AST_ZERO_VAL: assert property (done && (s_r.cmd.op == OP_WORD_ZERO) |=>
    ((($past(s_r.cmd.rp[0]) ? arch.bc : arch.ax)) == WM_WORD_ZERO))
    else $error("zero value wrong");
  AST_SWAP: assert property (done && (s_r.cmd.op == OP_WORD_SWAP) |=>
    (arch.ax == (!$past(s_r.cmd.rp[1]) ? $past(arch.bc) :
    ($past(s_r.cmd.rp[0]) ? $past(arch.hl) : $past(arch.de)))))
    else $error("word swap did not fetch the pair");
  AST_MOVE_FLAGS: assert property (done && (s_r.cmd.op <= OP_LDRP) |=>
    $stable(arch.f))
    else $error("word move changed flags");
  AST_AND_FLAGS: assert property (done && (s_r.cmd.op == OP_AND) &&
    (s_r.cmd.dst == DST_A) |=> $stable(arch.f.cy) && $stable(arch.f.ac) &&
    (arch.f.z == (arch.ax[15:8] == WM_BYTE_ZERO)))
    else $error("conjunction flags wrong");
  AST_RMW: assert property (first && !s_r.fram &&
    (s_r.cmd.dst == DST_SADDR) |-> mreq.rd && !done ##1 mreq.wr && done)
    else $error("short address update not read then write");
  AST_ADD_CY: assert property (done && (s_r.cmd.op == OP_ADD) &&
    (s_r.cmd.dst == DST_A) && (s_r.cmd.src == SRC_IMM) |=>
    (arch.f.cy == (({1'b0, $past(s_r.rf[WM_R_A])} +
    {1'b0, $past(s_r.cmd.imm)}) > 9'h0ff)))
    else $error("sum carry wrong");
endmodule

// ### tb/wm_mem_model.sv
// Behavioural RAM, code flash and data flash behind the execution unit.
// Assumes reads are answered in the strobe cycle and writes land on the edge.
`timescale 1ns/1ns
module wm_mem_model
  import wm_pkg::*;
(
  // Clock
  input wire logic clk_sys,
  // Request and answer
  input wire wm_pkg::wm_mreq_t mreq,
  output logic [15:0] mem_rdata,
  output wm_pkg::wm_region_t mem_region
);
  logic [15:0] mem [256];
  logic [15:0] last_r;
  initial
  begin
    for (int i = 0; i < 256; i++)
    begin
      mem[i] = {i[7:0] ^ 8'h5a, i[7:0] ^ 8'ha5};
    end
    last_r = 16'h0000;
  end
  // Idle bus shows the inverse of the last word, so stale data never matches
  always_comb
  begin
    mem_rdata = mreq.rd ? mem[mreq.addr[7:0]] : ~last_r;
    mem_region = (mreq.addr[15:8] == 8'h80) ? RG_CODE :
      (mreq.addr[19:16] == 4'h1) ? RG_DATA : RG_RAM;
  end
  // Only 256 words: addresses alias on their low byte
  always @(posedge clk_sys)
  begin
    if (mreq.rd)
      last_r <= mem[mreq.addr[7:0]];
    if (mreq.wr)
      mem[mreq.addr[7:0]] <= mreq.wide ? mreq.wdata :
        {mem[mreq.addr[7:0]][15:8], mreq.wdata[7:0]};
  end
endmodule

// ### tb/tb_top.sv
// Self-checking bench for the word move and byte arithmetic unit.
// Assumes the memory model maps 0x80xx to code flash and bank 1 to data.
`timescale 1ns/1ns
module tb_top;
  import wm_pkg::*;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic cmd_valid = 1'b0;
  wm_cmd_t cmd = '0;
  logic fetch_ram = 1'b0;
  logic es_wr = 1'b0;
  logic [3:0] es_wdata = 4'h0;
  logic sp_wr = 1'b0;
  logic [15:0] sp_wdata = 16'h0000;
  logic cmd_ready, done, ws;
  logic [2:0] instr_len;
  wm_mreq_t mreq;
  logic [15:0] mem_rdata, wd;
  wm_region_t mem_region;
  wm_arch_t arch;
  int num_errors = 0;
  int checks = 0;
  int cyc = 0;
  int n;
  logic [19:0] a1, wa;
  logic [7:0] ea = 8'h00;
  wm_flags_t ef = '0;
  logic [10:0] e;

  always #5 clk_sys = ~clk_sys;

  wm_exec u_wm_exec (.clk_sys, .rstn, .cmd_valid, .cmd, .fetch_ram,
    .cmd_ready, .done, .instr_len, .es_wr, .es_wdata, .sp_wr, .sp_wdata,
    .mreq, .mem_rdata, .mem_region, .arch);
  wm_mem_model u_wm_mem_model (.clk_sys, .mreq, .mem_rdata, .mem_region);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] pat(logic [7:0] i);
    return {i ^ 8'h5a, i ^ 8'ha5};
  endfunction

  // One selector feeds r, rp, disp and imm; each form reads only its own
  function automatic wm_cmd_t mk(wm_op_t op, wm_am_t am, wm_src_t s,
    wm_dst_t d, logic p, logic [7:0] sel, logic [15:0] w);
    return '{op, am, s, d, p, sel[2:0], sel[1:0], sel, w, sel};
  endfunction

  function automatic logic [10:0] ref_alu(wm_op_t op, logic [7:0] a,
    logic [7:0] b, wm_flags_t f);
    logic c;
    logic [8:0] s;
    logic [4:0] h;
    c = (op == OP_SUM_WITH_CARRY || op == OP_DIFF_WITH_BORROW) ? f.cy : 1'b0;
    if (op == OP_ADD || op == OP_SUM_WITH_CARRY)
    begin
      s = a + b + c;
      h = a[3:0] + b[3:0] + c;
    end
    else
    begin
      s = {1'b0, a} - b - c;
      h = {1'b0, a[3:0]} - b[3:0] - c;
    end
    if (op == OP_AND)
      return {a & b, (a & b) == 8'h00, f.ac, f.cy};
    return {s[7:0], s[7:0] == 8'h00, h[4], s[8]};
  endfunction

  task automatic chk(input logic ok, input string msg);
    checks++;
    if (ok !== 1'b1)
    begin
      $display("[FAIL] %0t %s", $time, msg);
      num_errors++;
    end
  endtask

  // Entered just after an edge while idle; returns one cycle after done
  task automatic run(input wm_cmd_t c, input logic fr = 1'b0);
    cmd = c;
    fetch_ram = fr;
    cmd_valid = 1'b1;
    @(posedge clk_sys);
    #1;
    cmd_valid = 1'b0;
    n = 1;
    a1 = mreq.addr;
    while (done !== 1'b1 && n < 40)
    begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    ws = mreq.wr;
    wa = mreq.addr;
    wd = mreq.wdata;
    @(posedge clk_sys);
    #1;
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    chk(arch === '0 && cmd_ready === 1'b1 && done === 1'b0, "reset state");
    chk(mreq.rd === 1'b0 && mreq.wr === 1'b0, "reset bus");
    rstn = 1'b1;
    es_wr = 1'b1;
    es_wdata = 4'h1;
    sp_wr = 1'b1;
    sp_wdata = 16'h8010;
    @(posedge clk_sys);
    #1;
    es_wr = 1'b0;
    sp_wr = 1'b0;
    chk(arch.es === 4'h1 && arch.sp === 16'h8010, "bank and stack load");
    $display("t_reset done");
  endtask

  task automatic t_arith();
    wm_op_t ops [8] = '{OP_ADD, OP_ADD, OP_SUM_WITH_CARRY, OP_SUB, OP_AND, OP_DIFF_WITH_BORROW,
      OP_SUM_WITH_CARRY, OP_ADD};
    logic [7:0] imm [8] = '{8'h8f, 8'h81, 8'h0f, 8'h21, 8'h0f, 8'h0f,
      8'h00, 8'h5c};
    run(mk(OP_WORD_ZERO, AM_DE, SRC_IMM, DST_A, 1'b0, 8'h00, 16'h0000));
    for (int i = 0; i < 8; i++)
    begin
      e = ref_alu(ops[i], ea, imm[i], ef);
      run(mk(ops[i], AM_DE, SRC_IMM, DST_A, 1'b0, imm[i], 16'h0000));
      ea = e[10:3];
      ef = e[2:0];
      chk(arch.ax[15:8] === ea, "acc result");
      chk(arch.f === ef, "acc flags");
      chk(n == 1 && instr_len === WM_LEN_2, "imm timing");
    end
    $display("t_arith done");
  endtask

  task automatic t_reg();
    run(mk(OP_WORD_ZERO, AM_DE, SRC_IMM, DST_A, 1'b0, 8'h01, 16'h0000));
    e = ref_alu(OP_ADD, 8'h00, ea, ef);
    run(mk(OP_ADD, AM_DE, SRC_REG, DST_REG, 1'b0, 8'h03, 16'h0000));
    ef = e[2:0];
    chk(arch.bc[15:8] === e[10:3] && arch.ax[15:8] === ea, "reg dst");
    chk(arch.f === ef && n == 1 && instr_len === WM_LEN_2, "reg");
    $display("t_reg done");
  endtask

  task automatic t_saddr();
    e = ref_alu(OP_ADD, 8'(pat(8'h50)), 8'h30, ef);
    run(mk(OP_ADD, AM_SADDR, SRC_IMM, DST_SADDR, 1'b0, 8'h30, 16'h0000));
    ef = e[2:0];
    chk(a1 === {WM_DEF_BANK, 16'hfe50} && ws === 1'b1 && wa === a1, "rmw");
    chk(wd[7:0] === e[10:3] && n == 2 && instr_len === WM_LEN_3, "rmw");
    chk(arch.f === ef && arch.ax[15:8] === ea, "rmw flags");
    e = ref_alu(OP_AND, e[10:3], 8'h30, ef);
    run(mk(OP_AND, AM_SADDR, SRC_IMM, DST_SADDR, 1'b0, 8'h30, 16'h0000));
    ef = e[2:0];
    chk(wd[7:0] === e[10:3] && ws === 1'b1 && n == 2, "and in place");
    chk(arch.f === ef && instr_len === WM_LEN_3, "and flags");
    $display("t_saddr done");
  endtask

  task automatic t_words();
    run(mk(OP_LDRP, AM_ABS, SRC_MEM, DST_A, 1'b0, 8'h02, 16'h0012));
    chk(arch.de === pat(8'h12) && n == 1 && instr_len === WM_LEN_3, "abs");
    run(mk(OP_LDRP, AM_SADDR, SRC_MEM, DST_A, 1'b0, 8'h23, 16'h0000));
    chk(arch.hl === pat(8'h43) && instr_len === WM_LEN_2, "short");
    run(mk(OP_LDRP, AM_ABS, SRC_MEM, DST_A, 1'b0, 8'h01, 16'h8020));
    chk(arch.bc === pat(8'h20) && n == 4, "code flash");
    run(mk(OP_LDW, AM_DE, SRC_MEM, DST_A, 1'b0, 8'h00, 16'h0000));
    // The pointer holds pat(12); the model aliases it to word b7
    chk(arch.ax === pat(8'hb7) && n == 1, "ind");
    chk(instr_len === WM_LEN_1, "ind length");
    chk(a1 === {WM_DEF_BANK, pat(8'h12)}, "default bank");
    run(mk(OP_STW, AM_HL_D, SRC_MEM, DST_A, 1'b1, 8'h02, 16'h0000));
    chk(ws === 1'b1 && wa === {4'h1, pat(8'h43) + 16'h0002}, "pfx");
    chk(wd === pat(8'hb7) && n == 2, "pfx data");
    chk(instr_len === WM_LEN_3, "pfx length");
    run(mk(OP_LDW, AM_SP_D, SRC_MEM, DST_A, 1'b0, 8'h04, 16'h0000));
    chk(arch.ax === pat(8'h14) && n == 1 && instr_len === WM_LEN_2, "sp");
    run(mk(OP_LDW, AM_BC_W, SRC_MEM, DST_A, 1'b0, 8'h00, 16'h0003));
    chk(a1 === {WM_DEF_BANK, pat(8'h20) + 16'h0003}, "based");
    chk(arch.ax === pat(8'h88) && instr_len === WM_LEN_3, "based");
    run(mk(OP_WORD_SWAP, AM_DE, SRC_REG, DST_A, 1'b0, 8'h02, 16'h0000));
    chk(arch.ax === pat(8'h12) && arch.de === pat(8'h88), "swap");
    chk(n == 1 && instr_len === WM_LEN_1, "swap timing");
    run(mk(OP_WORD_SET_ONE, AM_DE, SRC_IMM, DST_A, 1'b0, 8'h00, 16'h0000));
    chk(arch.ax === WM_WORD_ONE && n == 1, "set one");
    run(mk(OP_WORD_ZERO, AM_DE, SRC_IMM, DST_A, 1'b0, 8'h01, 16'h0000));
    chk(arch.bc === WM_WORD_ZERO && instr_len === WM_LEN_1, "zero");
    chk(arch.f === ef, "flags kept");
    ea = 8'h00;
    $display("t_words done");
  endtask

  task automatic t_flash();
    e = ref_alu(OP_ADD, ea, 8'(pat(8'he6)), ef);
    run(mk(OP_ADD, AM_HL, SRC_MEM, DST_A, 1'b1, 8'h00, 16'h0000));
    chk(n == 5 && a1 === {4'h1, pat(8'h43)}, "data flash byte");
    chk(arch.ax[15:8] === e[10:3] && arch.f === e[2:0], "flash sum");
    run(mk(OP_LDW, AM_HL, SRC_MEM, DST_A, 1'b1, 8'h00, 16'h0000));
    chk(n == 2 && arch.ax === pat(8'he6), "data flash word");
    run(mk(OP_ADD, AM_DE, SRC_IMM, DST_A, 1'b0, 8'h01, 16'h0000), 1'b1);
    chk(n == 5, "ram fetch");
    $display("t_flash done");
  endtask

  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      num_errors++;
      finish_test();
    end
  end

  initial
  begin
    repeat (5) @(posedge clk_sys);
    #1;
    t_reset();
    t_arith();
    t_reg();
    t_saddr();
    t_words();
    t_flash();
    finish_test();
  end
endmodule
